// [mlat_device.sv]
// Purpose: Device end: shifts adapt words, times approximate tune, applies exact set
// Assumes: Serial inputs synchronous to ref_clk; refTick marks each detector cycle
// Notes:   A 16-bit word loads the reference holding buffer, 24-bit the feedback
// Contract
// - Host sends approx ref, approx fb, exact ref, exact fb
// - Timer code 101 gives 32 detector cycles
// - Exact word code 001 selects low-current output
// - Host sets feedback MSB when mode high
// - Lock window bit zero selects narrow window
// - Ratio bit zero selects 4:1 current ratio
// - Host uses short address-less words
// - Exact shift time falls within approximate interval
// - Exact values transfer only after timer expiry
// - Expiry switches loop to low-current output
// - Feedback write moves held reference into counter
// - Adapt applies to main loop only
module mlat_device (
  // Clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           sys_rst,
  // Serial link
  mlat_if.dev                                 link,
  // Detector cycle tick
  input  wire logic                           refTick,
  // Active main loop settings
  output logic [mlat_pkg::REF_W-1:0]          activeRefValue,
  output logic [mlat_pkg::CNT_W-1:0]          activeFbValue,
  output logic                                lowCurrentSelect,
  output logic                                narrowLockWindow,
  output logic                                ratioFourToOne,
  output logic                                approxTuneActive
);
  // Serial front end
  logic [mlat_pkg::FB_W-1:0]  shift_q;
  logic [4:0]                 bitCnt_q;
  logic                       clkPrev_q;
  logic                       enPrev_q;
  // Held and pending main-loop values
  logic [mlat_pkg::REF_W-1:0] refHold_q;
  logic [mlat_pkg::REF_W-1:0] exactRef_q;
  logic [mlat_pkg::FB_W-1:0]  exactFb_q;
  logic                       exactPend_q;
  logic [7:0]                 timer_q;
  // Word decode and timer events
  logic                       clkRise;
  logic                       wordDone;
  logic                       refWord;
  logic                       fbWord;
  logic [2:0]                 tsel;
  logic [7:0]                 interval;
  logic                       tickWhileActive;
  logic                       expire;
  logic                       loadDirect;
  logic                       holdExact;
  logic                       applyShift;
  logic                       applyPend;

  assign clkRise         = link.serClk && !clkPrev_q;
  assign wordDone        = enPrev_q && !link.serEnable;
  assign refWord         = wordDone && (bitCnt_q == 5'(mlat_pkg::REF_W));
  assign fbWord          = wordDone && (bitCnt_q == 5'(mlat_pkg::FB_W));
  assign tsel            = shift_q[mlat_pkg::FB_TSEL_HI:mlat_pkg::FB_TSEL_LO];
  assign tickWhileActive = approxTuneActive && refTick;
  assign expire          = tickWhileActive && (timer_q == mlat_pkg::TIMER_ONE);
  // Feedback word outside approximate tune is applied at once
  assign loadDirect      = fbWord && !approxTuneActive;
  // Feedback word during approximate tune is the exact word
  assign holdExact       = fbWord && approxTuneActive;
  // Exact word landing on the expiry edge goes straight through, so expiry is never lost
  assign applyShift      = loadDirect || (holdExact && expire);
  assign applyPend       = expire && !holdExact && exactPend_q;

  // Timer length from the select bits of the word just shifted
  always_comb begin
    unique case (tsel)
      mlat_pkg::TSEL_8_CYCLES:   interval = mlat_pkg::TIMER_8;
      mlat_pkg::TSEL_16_CYCLES:  interval = mlat_pkg::TIMER_16;
      mlat_pkg::TSEL_32_CYCLES:  interval = mlat_pkg::TIMER_32;
      mlat_pkg::TSEL_64_CYCLES:  interval = mlat_pkg::TIMER_64;
      mlat_pkg::TSEL_128_CYCLES: interval = mlat_pkg::TIMER_128;
      // Codes without a timer apply the word at once
      default:                   interval = mlat_pkg::TIMER_ZERO;
    endcase
  end

  // Edge history of serial clock and enable
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      clkPrev_q <= 1'b0;
      enPrev_q  <= 1'b0;
    end else begin
      clkPrev_q <= link.serClk;
      enPrev_q  <= link.serEnable;
    end
  end

  // Bit count, kept one edge past the enable fall for the word decode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bitCnt_q <= mlat_pkg::BITS_ZERO;
    end else if (!link.serEnable && !enPrev_q) begin
      bitCnt_q <= mlat_pkg::BITS_ZERO;
    end else if (link.serEnable && clkRise) begin
      bitCnt_q <= bitCnt_q + 5'h01;
    end
  end

  // Serial shift register, MSB first
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shift_q <= '0;
    end else if (link.serEnable && clkRise) begin
      shift_q <= {shift_q[mlat_pkg::FB_W-2:0], link.serData};
    end
  end

  // Reference holding buffer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      refHold_q <= '0;
    end else if (refWord) begin
      refHold_q <= shift_q[mlat_pkg::REF_W-1:0];
    end
  end

  // Adapt timer; exists for the main loop only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      timer_q <= mlat_pkg::TIMER_ZERO;
    end else if (loadDirect) begin
      timer_q <= interval;
    end else if (expire) begin
      timer_q <= mlat_pkg::TIMER_ZERO;
    end else if (tickWhileActive) begin
      // Keeps counting while the exact set shifts in
      timer_q <= timer_q - 8'h01;
    end
  end

  // Approximate tune runs while the timer counts
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      approxTuneActive <= 1'b0;
    end else if (loadDirect) begin
      approxTuneActive <= (interval != mlat_pkg::TIMER_ZERO);
    end else if (expire) begin
      approxTuneActive <= 1'b0;
    end
  end

  // Exact set waiting for expiry
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      exactPend_q <= 1'b0;
    end else if (loadDirect || expire) begin
      exactPend_q <= 1'b0;
    end else if (holdExact) begin
      exactPend_q <= 1'b1;
    end
  end

  // Exact values held back from the counters
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      exactRef_q <= '0;
      exactFb_q  <= '0;
    end else if (holdExact) begin
      exactRef_q <= refHold_q;
      exactFb_q  <= shift_q;
    end
  end

  // Active divide values: double-buffer transfer on a feedback write outside approximate tune, or at expiry
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      activeRefValue <= '0;
      activeFbValue  <= '0;
    end else if (applyShift) begin
      activeRefValue <= refHold_q;
      activeFbValue  <= shift_q[mlat_pkg::FB_CNT_HI:0];
    end else if (applyPend) begin
      activeRefValue <= exactRef_q;
      activeFbValue  <= exactFb_q[mlat_pkg::FB_CNT_HI:0];
    end
  end

  // Lock window and current ratio follow the word applied
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      narrowLockWindow <= 1'b1;
      ratioFourToOne   <= 1'b1;
    end else if (applyShift) begin
      narrowLockWindow <= !shift_q[mlat_pkg::FB_WIN_BIT];
      ratioFourToOne   <= !shift_q[mlat_pkg::FB_RATIO_BIT];
    end else if (applyPend) begin
      narrowLockWindow <= !exactFb_q[mlat_pkg::FB_WIN_BIT];
      ratioFourToOne   <= !exactFb_q[mlat_pkg::FB_RATIO_BIT];
    end
  end

  // Detector output choice: high current during approximate tune
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lowCurrentSelect <= 1'b0;
    end else if (loadDirect) begin
      lowCurrentSelect <= (tsel == mlat_pkg::TSEL_LOW_CURRENT);
    end else if (expire) begin
      lowCurrentSelect <= 1'b1;
    end
  end
endmodule // mlat_device

// [mlat_pkg.sv]
// Purpose: Shared constants for the main-loop adapt tuning link
// Assumes: Host and device share ref_clk; serial link is clock, data, enable
// Notes:   Feedback word is 24 bits, reference word 16 bits
package mlat_pkg;
  localparam int REF_W = 16;
  localparam int FB_W  = 24;
  localparam int CNT_W = 18;
  // Feedback word field positions
  localparam int FB_MODE_BIT   = 23;
  localparam int FB_WIN_BIT    = 22;
  localparam int FB_TSEL_HI    = 21;
  localparam int FB_TSEL_LO    = 19;
  localparam int FB_RATIO_BIT  = 18;
  localparam int FB_CNT_HI     = 17;
  // Timer select codes
  localparam logic [2:0] TSEL_LOW_CURRENT = 3'h1;
  localparam logic [2:0] TSEL_32_CYCLES   = 3'h5;
  localparam logic [2:0] TSEL_8_CYCLES    = 3'h2;
  localparam logic [2:0] TSEL_16_CYCLES   = 3'h3;
  localparam logic [2:0] TSEL_64_CYCLES   = 3'h6;
  localparam logic [2:0] TSEL_128_CYCLES  = 3'h7;
  // Interval lengths in reference-detector cycles
  localparam logic [7:0] TIMER_32 = 8'h20;
  localparam logic [7:0] TIMER_8  = 8'h08;
  localparam logic [7:0] TIMER_16 = 8'h10;
  localparam logic [7:0] TIMER_64 = 8'h40;
  localparam logic [7:0] TIMER_128 = 8'h80;
  localparam logic [7:0] TIMER_ZERO = 8'h00;
  localparam logic [7:0] TIMER_ONE  = 8'h01;
  // Serial clock divider: half period in ref_clk cycles
  localparam logic [3:0] SCLK_HALF = 4'h4;
  localparam logic [4:0] BITS_ZERO = 5'h00;
  typedef enum logic [1:0] {
    WORD_APPROX_REF = 2'b00,
    WORD_APPROX_FB  = 2'b01,
    WORD_EXACT_REF  = 2'b10,
    WORD_EXACT_FB   = 2'b11
  } mlat_word_t;
endpackage

// [mlat_if.sv]
// Purpose: Serial link between host and synthesizer adapt control
// Assumes: All signals synchronous to ref_clk
// Notes:   Data shifts MSB first; word ends when enable falls
interface mlat_if;
  logic serClk;
  logic serData;
  logic serEnable;
  modport host (output serClk, output serData, output serEnable);
  modport dev  (input serClk, input serData, input serEnable);
endinterface

// [mlat_host.sv]
// Purpose: Host end: sends the four adapt words in order
// Assumes: One tune request at a time; ready shows when idle
// Notes:   Serial clock is ref_clk divided by twice SCLK_HALF
module mlat_host (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  // Tune request
  input  wire logic                     tuneStart,
  input  wire logic                     modePinHigh,
  input  wire logic [15:0]              approxRef,
  input  wire logic [23:0]              approxFb,
  input  wire logic [15:0]              exactRef,
  input  wire logic [23:0]              exactFb,
  output logic                          hostReady,
  // Serial link
  mlat_if.host                          link
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_GAP   = 2'b10
  } mlat_hstate_t;

  localparam logic [4:0] REF_BITS = 5'(mlat_pkg::REF_W);
  localparam logic [4:0] FB_BITS  = 5'(mlat_pkg::FB_W);
  localparam logic [mlat_pkg::FB_W-mlat_pkg::REF_W-1:0] REF_PAD = '0;

  mlat_hstate_t               state_q;
  mlat_pkg::mlat_word_t       word_q;
  logic [mlat_pkg::FB_W-1:0]  shift_q;
  logic [4:0]                 bits_q;
  logic [3:0]                 div_q;
  logic                       tick;
  logic [mlat_pkg::REF_W-1:0] aRef_q;
  logic [mlat_pkg::FB_W-1:0]  aFb_q;
  logic [mlat_pkg::REF_W-1:0] eRef_q;
  logic [mlat_pkg::FB_W-1:0]  eFb_q;
  logic [mlat_pkg::FB_W-1:0]  firstWord;
  logic [mlat_pkg::FB_W-1:0]  nextWord;
  logic [4:0]                 nextBits;

  assign tick      = (div_q == mlat_pkg::SCLK_HALF - 4'h1);
  assign firstWord = {approxRef, REF_PAD};

  // Word that follows the one just sent
  always_comb begin
    unique case (word_q)
      mlat_pkg::WORD_APPROX_REF: begin
        nextWord = aFb_q;
        nextBits = FB_BITS;
      end
      mlat_pkg::WORD_APPROX_FB: begin
        nextWord = {eRef_q, REF_PAD};
        nextBits = REF_BITS;
      end
      mlat_pkg::WORD_EXACT_REF: begin
        nextWord = eFb_q;
        nextBits = FB_BITS;
      end
      mlat_pkg::WORD_EXACT_FB: begin
        nextWord = {aRef_q, REF_PAD};
        nextBits = REF_BITS;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || state_q == ST_IDLE || tick) div_q <= 4'h0;
    else div_q <= div_q + 4'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q        <= ST_IDLE;
      word_q         <= mlat_pkg::WORD_APPROX_REF;
      shift_q        <= '0;
      bits_q         <= 5'h00;
      hostReady      <= 1'b0;
      link.serClk    <= 1'b0;
      link.serData   <= 1'b0;
      link.serEnable <= 1'b0;
      aRef_q         <= '0;
      aFb_q          <= '0;
      eRef_q         <= '0;
      eFb_q          <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          hostReady <= 1'b1;
          if (tuneStart) begin
            aRef_q         <= approxRef;
            aFb_q          <= {approxFb[mlat_pkg::FB_MODE_BIT] | modePinHigh, approxFb[mlat_pkg::FB_WIN_BIT:0]};
            eRef_q         <= exactRef;
            eFb_q          <= {exactFb[mlat_pkg::FB_MODE_BIT] | modePinHigh, exactFb[mlat_pkg::FB_WIN_BIT],
                               mlat_pkg::TSEL_LOW_CURRENT, exactFb[mlat_pkg::FB_RATIO_BIT:0]};
            // First bit set up half a serial period ahead of its clock rise
            link.serData   <= firstWord[mlat_pkg::FB_W-1];
            shift_q        <= {firstWord[mlat_pkg::FB_W-2:0], 1'b0};
            bits_q         <= REF_BITS;
            word_q         <= mlat_pkg::WORD_APPROX_REF;
            hostReady      <= 1'b0;
            link.serEnable <= 1'b1;
            state_q        <= ST_SHIFT;
          end
        end
        ST_SHIFT: if (tick) begin
          if (!link.serClk) begin
            link.serClk <= 1'b1;
            bits_q      <= bits_q - 5'h01;
          end else begin
            link.serClk <= 1'b0;
            if (bits_q == 5'h00) begin
              link.serEnable <= 1'b0;
              state_q        <= ST_GAP;
            end else begin
              // Data moves on the falling serial clock only
              link.serData <= shift_q[mlat_pkg::FB_W-1];
              shift_q      <= {shift_q[mlat_pkg::FB_W-2:0], 1'b0};
            end
          end
        end
        ST_GAP: if (tick) begin
          if (word_q == mlat_pkg::WORD_EXACT_FB) begin
            state_q <= ST_IDLE;
          end else begin
            word_q         <= mlat_pkg::mlat_word_t'(word_q + 2'b01);
            link.serData   <= nextWord[mlat_pkg::FB_W-1];
            shift_q        <= {nextWord[mlat_pkg::FB_W-2:0], 1'b0};
            bits_q         <= nextBits;
            link.serEnable <= 1'b1;
            state_q        <= ST_SHIFT;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // mlat_host

// [mlat_checker.sv]
// Purpose: Concurrent checks on the adapt link and the device's main-loop outputs
// Assumes: One ref_clk domain; sys_rst synchronous, active high
// Notes:   Instanced beside the interface in tb_top
module mlat_checker (
  // Clock and reset
  input wire logic                         ref_clk,
  input wire logic                         sys_rst,
  // Link and host status
  input wire logic                         serClk,
  input wire logic                         serData,
  input wire logic                         serEnable,
  input wire logic                         hostReady,
  // Device side
  input wire logic                         refTick,
  input wire logic                         approxTuneActive,
  input wire logic                         lowCurrentSelect,
  input wire logic                         narrowLockWindow,
  input wire logic                         ratioFourToOne,
  input wire logic [mlat_pkg::REF_W-1:0]   activeRefValue,
  input wire logic [mlat_pkg::CNT_W-1:0]   activeFbValue
);
  logic [7:0] tickCnt_q;
  // Detector ticks seen during approximate tune
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !approxTuneActive) tickCnt_q <= 8'h00;
    else if (refTick) tickCnt_q <= tickCnt_q + 8'h01;
  end
  property p_rst_out;
    @(posedge ref_clk) disable iff (sys_rst) $fell(sys_rst) |-> narrowLockWindow && ratioFourToOne && !lowCurrentSelect;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset values wrong");
  property p_timer_len;
    @(posedge ref_clk) disable iff (sys_rst) $fell(approxTuneActive) |-> tickCnt_q == 8'h20;
  endproperty
  a_timer_len: assert property (p_timer_len) else $error("approx interval not 32 ticks");
  property p_expiry_low;
    @(posedge ref_clk) disable iff (sys_rst) $fell(approxTuneActive) |-> lowCurrentSelect;
  endproperty
  a_expiry_low: assert property (p_expiry_low) else $error("no low current after expiry");
  property p_approx_high;
    @(posedge ref_clk) disable iff (sys_rst) approxTuneActive |-> !lowCurrentSelect;
  endproperty
  a_approx_high: assert property (p_approx_high) else $error("low current during approx");
  property p_held;
    @(posedge ref_clk) disable iff (sys_rst)
      approxTuneActive && $past(approxTuneActive) |-> $stable(activeFbValue) && $stable(activeRefValue);
  endproperty
  a_held: assert property (p_held) else $error("exact set applied early");
  property p_ready_idle;
    @(posedge ref_clk) disable iff (sys_rst) hostReady |-> !serEnable;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("host busy while ready");
  property p_frame_start;
    @(posedge ref_clk) disable iff (sys_rst) $rose(serEnable) |-> !serClk;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("clock high at frame start");
  property p_data_stable;
    @(posedge ref_clk) disable iff (sys_rst) serEnable && $rose(serClk) |-> $stable(serData);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved at clock rise");
endmodule // mlat_checker

// [tb_top.sv]
// Purpose: Host and device joined by the link; adapt sequences checked end to end
// Assumes: Inputs driven on the falling edge; refTick every 16 cycles
// Notes:   Wire sniffer rebuilds each word from the link
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, tuneStart = 1'b0, modePinHigh = 1'b0, refTick = 1'b0;
  logic [15:0] approxRef = 16'h0000, exactRef = 16'h0000;
  logic [23:0] approxFb = 24'h000000, exactFb = 24'h000000, sh = 24'h000000, lastWord;
  logic [4:0]  bitCnt = 5'h00, lastCnt;
  logic [3:0]  tickDiv = 4'h0;
  logic        serClkQ = 1'b0, serEnQ = 1'b0, hostReady, approxTuneActive, lowCurrentSelect;
  logic        narrowLockWindow, ratioFourToOne;
  logic [15:0] activeRefValue;
  logic [17:0] activeFbValue;
  int          err_total = 0, compares = 0;
  mlat_if link_i ();
  mlat_host mlat_host_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .tuneStart(tuneStart), .modePinHigh(modePinHigh),
    .approxRef(approxRef), .approxFb(approxFb), .exactRef(exactRef), .exactFb(exactFb), .hostReady(hostReady),
    .link(link_i));
  mlat_device mlat_device_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link_i), .refTick(refTick),
    .activeRefValue(activeRefValue), .activeFbValue(activeFbValue), .lowCurrentSelect(lowCurrentSelect),
    .narrowLockWindow(narrowLockWindow), .ratioFourToOne(ratioFourToOne), .approxTuneActive(approxTuneActive));
  mlat_checker mlat_checker_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .serClk(link_i.serClk),
    .serData(link_i.serData), .serEnable(link_i.serEnable), .hostReady(hostReady), .refTick(refTick),
    .approxTuneActive(approxTuneActive), .lowCurrentSelect(lowCurrentSelect), .narrowLockWindow(narrowLockWindow),
    .ratioFourToOne(ratioFourToOne), .activeRefValue(activeRefValue), .activeFbValue(activeFbValue));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    tickDiv <= tickDiv + 4'h1;
    refTick <= (tickDiv == 4'hf);
  end
  // Rebuild each word from the wire as the device samples it
  always @(posedge ref_clk) begin
    serClkQ <= link_i.serClk;
    serEnQ <= link_i.serEnable;
    if (link_i.serEnable && link_i.serClk && !serClkQ) begin
      sh <= {sh[22:0], link_i.serData};
      bitCnt <= bitCnt + 5'h01;
    end
    if (!link_i.serEnable && serEnQ) begin
      lastWord <= sh;
      lastCnt <= bitCnt;
      bitCnt <= 5'h00;
    end
  end
  task automatic close_out();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic send(input logic [15:0] r1, input logic [23:0] n1, input logic [15:0] r2,
                      input logic [23:0] n2, input logic mode);
    int i;
    @(negedge ref_clk);
    {approxRef, approxFb, exactRef, exactFb, modePinHigh, tuneStart} = {r1, n1, r2, n2, mode, 1'b1};
    @(negedge ref_clk);
    tuneStart = 1'b0;
    for (i = 0; i < 4000 && !(hostReady === 1'b1 && i > 4); i++) @(negedge ref_clk);
    if (i >= 4000) begin err_total++; close_out(); end
  endtask
  task automatic t_adapt();
    int i;
    send(16'h079b, 24'ha859fa, 16'h1e60, 24'h89675a, 1'b0);
    `CHK(approxTuneActive, 1'b1)
    `CHK(activeRefValue, 16'h079b)
    `CHK(activeFbValue, 18'h059fa)
    `CHK({narrowLockWindow, ratioFourToOne}, 2'b11)
    `CHK(lastWord, 24'h89675a)
    `CHK(lastCnt, 5'h18)
    for (i = 0; i < 2000 && approxTuneActive === 1'b1; i++) @(negedge ref_clk);
    if (i >= 2000) begin err_total++; close_out(); end
    `CHK(i > 100, 1'b1)
    `CHK(activeRefValue, 16'h1e60)
    `CHK(activeFbValue, 18'h1675a)
    `CHK(lowCurrentSelect, 1'b1)
  endtask
  task automatic t_direct_mode();
    logic seen;
    fork
      begin seen = 1'b0; repeat (1500) @(negedge ref_clk) seen |= approxTuneActive; end
      send(16'h1234, 24'h4c1234, 16'h4321, 24'h7c5678, 1'b1);
    join_any
    repeat (4) @(negedge ref_clk);
    `CHK(seen, 1'b0)
    `CHK(lastWord[23], 1'b1)
    `CHK(lastWord[21:19], 3'h1)
    `CHK(activeRefValue, 16'h4321)
    `CHK(activeFbValue, 18'h05678)
    `CHK(lowCurrentSelect, 1'b1)
    `CHK({narrowLockWindow, ratioFourToOne}, 2'b00)
    disable fork;
  endtask
  initial begin
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    t_adapt();
    t_direct_mode();
    t_adapt();
    close_out();
  end
endmodule // tb_top
